/* logic/general_timer_unit.sv */
// General timer unit: prescaler, modulo up-counter, overflow flag, APB registers.
// Usage notes
// Every register answers in the cycle after its setup cycle; the slave never inserts wait states.
// While the processor waits, every access is refused with an error answer and read data of zero.
// Software cannot touch the timer then, so the halt bit must stay clear for the timer to wake it.
// Reads and writes of unmapped offsets have no effect and return zero with an error answer.
// The modulo pair is written high byte first; the new word takes effect with the low-byte write.
// Between the two writes no overflow is flagged, so a half-written pair cannot raise a request.
// Clear the counter before a new modulo: a count above the new value runs to the top first.
// A high-byte read of the counter freezes the low byte until the low byte itself is read.
// The freeze also holds across break; a debugger should read the low byte before it resumes.
// The clear bit drops that freeze as well, so both counter bytes read zero after a clear that also sets the halt bit.
// The pin clock passes two flops and counts on rising edges only, three bus clocks late.
// Each pin phase must outlast one bus clock to be seen by the synchroniser.
// Status flags are guarded during break unless the processor's clear enable is set.
// A clear sequence armed before break still completes with the zero write after break.
// An overflow in the cycle of a clearing write wins, so a request is never lost.
// Stop and break freeze the prescaler with the counter, so the divide phase is kept.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "timer_params.svh"
module general_timer_unit
    import timer_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Processor conditions.
    input  wire cpu_state_t  cpu_state,
    // External count clock pin and its port direction bit.
    input  wire logic        ext_count_clock_pin,
    input  wire logic        port_d_direction_bit,
    output logic             ext_pin_force_input,
    // Interrupt request and wake-up.
    output logic             overflow_irq,
    output logic             wake_request
);
    // ********************************************************************
    // Registers
    // ********************************************************************
    // Only the counter, the prescaler, the overflow flag, the clear state, the read latch and the pin stages change without a bus write.
    logic [15:0]           count_r;
    logic [15:0]           modulo_r;
    logic [7:0]            modulo_high_hold_r;
    logic                  modulo_pending_r;
    logic [7:0]            low_latch_r;
    logic                  low_latched_r;
    logic [`PRESCALE_W-1:0] prescale_r;
    logic [2:0]            prescale_select;
    logic                  overflow_flag;
    logic                  overflow_irq_enable;
    logic                  counter_halt;
    clr_state_t            clr_state_r;
    logic                  ext_sync1_r;
    logic                  ext_sync2_r;
    logic                  ext_prev_r;

    // ********************************************************************
    // Bus decode
    // ********************************************************************
    logic access;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic protect;
    // Accesses are refused while the processor waits; refusal shows as an error answer.
    assign access  = psel && penable && !cpu_state.wait_mode;
    assign wr_en   = access && pwrite;
    assign rd_en   = access && !pwrite;
    // Only the five word offsets decode; every other address answers with an error.
    assign mapped  = (paddr == `OFS_STATUS_CONTROL) || (paddr == `OFS_COUNTER_HIGH) ||
                     (paddr == `OFS_COUNTER_LOW) || (paddr == `OFS_MODULO_HIGH) ||
                     (paddr == `OFS_MODULO_LOW);
    // Flags are guarded during break unless software allowed clearing.
    assign protect = cpu_state.break_state && !cpu_state.break_clear_enable;

    // ********************************************************************
    // Counter clock enable
    // ********************************************************************
    logic running;
    logic tick;
    logic ext_edge;
    logic div_tick;
    logic clr_write;
    // Stop, break and halt freeze; wait mode does not stop counting.
    // Break freezes the count so that a debugger sees a still value.
    assign running   = !cpu_state.stop_mode && !cpu_state.break_state && !counter_halt;
    assign ext_edge  = ext_sync2_r && !ext_prev_r;
    // Divider decode: code k below 7 gives one tick every two to the power k running bus clocks; code 7 takes the pin edge.
    always_comb begin
        div_tick = 1'b0;
        unique case (prescale_select)
            3'h0: div_tick = 1'b1;
            3'h1: div_tick = prescale_r[0:0] == 1'h1;
            3'h2: div_tick = prescale_r[1:0] == 2'h3;
            3'h3: div_tick = prescale_r[2:0] == 3'h7;
            3'h4: div_tick = prescale_r[3:0] == 4'hF;
            3'h5: div_tick = prescale_r[4:0] == 5'h1F;
            3'h6: div_tick = prescale_r[5:0] == 6'h3F;
            3'h7: div_tick = ext_edge;
        endcase
    end
    assign tick      = running && div_tick;
    assign clr_write = wr_en && (paddr == `OFS_STATUS_CONTROL) && pwdata[`BIT_CLEAR];

    // Pin synchroniser: only the second stage feeds the edge detector.
    // All stages reset low, the idle level of the pin, so no false edge follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
            ext_prev_r  <= 1'b0;
        end else begin
            ext_sync1_r <= ext_count_clock_pin;
            ext_sync2_r <= ext_sync1_r;
            ext_prev_r  <= ext_sync2_r;
        end
    end

    // Prescaler runs only while the counter may count, so halting keeps the phase.
    // A clear write restarts the divide phase together with the counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_r <= '0;
        end else if (clr_write) begin
            prescale_r <= '0;
        end else if (running) begin
            prescale_r <= prescale_r + 1'b1;
        end
    end

    // Counter; the tick that finds the modulo value returns it to zero, the next tick counts on.
    // The clear write wins over a tick, so halt plus clear leaves the counter parked at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
        end else if (clr_write) begin
            count_r <= 16'h0000;
        end else if (tick) begin
            if (count_r == modulo_r) begin
                count_r <= 16'h0000;
            end else begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    // ********************************************************************
    // Status and control register
    // ********************************************************************
    logic overflow_set;
    logic status_read;
    logic status_write;
    // Overflow is counted at the rollover unless a modulo update is half done.
    assign overflow_set = tick && (count_r == modulo_r) && !modulo_pending_r;
    assign status_read  = rd_en && (paddr == `OFS_STATUS_CONTROL);
    assign status_write = wr_en && (paddr == `OFS_STATUS_CONTROL);

    // Control bits; the halt bit comes out of reset set.
    // The clear bit is not stored; it acts only in the cycle of its write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq_enable <= 1'b0;
            counter_halt        <= 1'b1;
            prescale_select     <= `RST_PRESCALE;
        end else if (status_write) begin
            overflow_irq_enable <= pwdata[`BIT_OVF_IRQ_EN];
            counter_halt        <= pwdata[`BIT_HALT];
            prescale_select     <= pwdata[`PS_MSB:`PS_LSB];
        end
    end

    // Two-step clear: a read showing the flag set arms, a zero write then clears.
    // A new overflow disarms and wins, so no interrupt is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
            clr_state_r   <= CLR_IDLE;
        end else if (overflow_set) begin
            overflow_flag <= 1'b1;
            clr_state_r   <= CLR_IDLE;
        end else begin
            unique case (clr_state_r)
                CLR_IDLE: begin
                    if (status_read && overflow_flag && !protect) begin
                        clr_state_r <= CLR_ARMED;
                    end
                end
                CLR_ARMED: begin
                    if (status_write && !pwdata[`BIT_OVF_FLAG] && !protect) begin
                        overflow_flag <= 1'b0;
                        clr_state_r   <= CLR_IDLE;
                    end
                end
            endcase
        end
    end

    // ********************************************************************
    // Modulo registers
    // ********************************************************************
    // The high byte is held aside so the pair changes as one word.
    // The pending mark lets the overflow logic ignore rollovers until the pair is whole.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modulo_r           <= `RST_MODULO;
            modulo_high_hold_r <= 8'hFF;
            modulo_pending_r   <= 1'b0;
        end else if (wr_en && (paddr == `OFS_MODULO_HIGH)) begin
            modulo_high_hold_r <= pwdata[7:0];
            modulo_pending_r   <= 1'b1;
        end else if (wr_en && (paddr == `OFS_MODULO_LOW)) begin
            modulo_r         <= {modulo_high_hold_r, pwdata[7:0]};
            modulo_pending_r <= 1'b0;
        end
    end

    // ********************************************************************
    // Counter read latch
    // ********************************************************************
    // The latch survives break on purpose; software must read the low byte or write the clear bit to release it.
    // Only the first high-byte read latches; later ones leave the buffered byte alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_latch_r   <= 8'h00;
            low_latched_r <= 1'b0;
        end else if (clr_write) begin
            low_latch_r   <= 8'h00;
            low_latched_r <= 1'b0;
        end else if (rd_en && (paddr == `OFS_COUNTER_HIGH) && !low_latched_r) begin
            low_latch_r   <= count_r[7:0];
            low_latched_r <= 1'b1;
        end else if (rd_en && (paddr == `OFS_COUNTER_LOW)) begin
            low_latched_r <= 1'b0;
        end
    end

    // ********************************************************************
    // Read data and answer
    // ********************************************************************
    logic [7:0] rd_byte;
    // Read byte mux; the modulo high byte shows the held byte, so software sees what it wrote.
    always_comb begin
        rd_byte = 8'h00;
        if (paddr == `OFS_STATUS_CONTROL) begin
            // The clear bit always reads as zero.
            rd_byte = {overflow_flag, overflow_irq_enable, counter_halt, 1'b0, 1'b0, prescale_select};
        end else if (paddr == `OFS_COUNTER_HIGH) begin
            rd_byte = count_r[15:8];
        end else if (paddr == `OFS_COUNTER_LOW) begin
            rd_byte = low_latched_r ? low_latch_r : count_r[7:0];
        end else if (paddr == `OFS_MODULO_HIGH) begin
            rd_byte = modulo_high_hold_r;
        end else if (paddr == `OFS_MODULO_LOW) begin
            rd_byte = modulo_r[7:0];
        end
    end

    // Zero-wait slave: answer flops load in the setup cycle, so they stand for the access cycle only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (!mapped || cpu_state.wait_mode);
        end
    end

    // Read data loads with the answer; refused and unmapped reads return zero, so nothing leaks in wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite && mapped && !cpu_state.wait_mode) begin
            prdata <= {24'h000000, rd_byte};
        end else begin
            prdata <= 32'h00000000;
        end
    end

    // ********************************************************************
    // Pin and interrupt outputs
    // ********************************************************************
    // Direction bit is overridden while the pin clocks the counter.
    // Outside that mode the port keeps the pin, whatever its direction bit says.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pin_force_input <= 1'b0;
        end else begin
            ext_pin_force_input <= (prescale_select == `PS_EXT_CLOCK) || !port_d_direction_bit ?
                                   (prescale_select == `PS_EXT_CLOCK) : 1'b0;
        end
    end

    // Interrupt request is a level that follows the flag while enabled, one clock late.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq <= 1'b0;
        end else begin
            overflow_irq <= overflow_flag && overflow_irq_enable;
        end
    end

    // Wake-up is the enabled request qualified by wait mode, with the same one-clock delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= overflow_flag && overflow_irq_enable && cpu_state.wait_mode;
        end
    end
endmodule : general_timer_unit

/* pkg/timer_params.svh */
// Register offsets, field positions, reset values, codes and the prescaler width of the general timer unit.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
// ********************************************************************
// Register byte offsets
// ********************************************************************
`define OFS_STATUS_CONTROL 12'h000
`define OFS_COUNTER_HIGH   12'h004
`define OFS_COUNTER_LOW    12'h008
`define OFS_MODULO_HIGH    12'h00C
`define OFS_MODULO_LOW     12'h010
// ********************************************************************
// Status and control field positions
// ********************************************************************
`define BIT_OVF_FLAG       7
`define BIT_OVF_IRQ_EN     6
`define BIT_HALT           5
`define BIT_CLEAR          4
`define PS_MSB             2
`define PS_LSB             0
// ********************************************************************
// Reset values and codes
// ********************************************************************
`define RST_MODULO         16'hFFFF
`define RST_PRESCALE       3'h0
`define PS_EXT_CLOCK       3'h7
`define PRESCALE_W         6
`endif

/* pkg/timer_pkg.sv */
// Types shared by the general timer unit.
package timer_pkg;
    // Low-power and debug conditions of the processor, grouped.
    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic break_state;
        logic break_clear_enable;
    } cpu_state_t;
    // State of the two-step overflow clear.
    typedef enum logic [0:0] {
        CLR_IDLE  = 1'b0,
        CLR_ARMED = 1'b1
    } clr_state_t;
endpackage : timer_pkg

/* verification/timer_asserts.sv */
// Port checks of the general timer unit.
`timescale 1ns/10ps
module timer_asserts
    import timer_pkg::*;
(
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Processor state and pins.
    input wire cpu_state_t  cpu_state,
    input wire logic        ext_count_clock_pin,
    input wire logic        port_d_direction_bit,
    input wire logic        ext_pin_force_input,
    input wire logic        overflow_irq,
    input wire logic        wake_request
);
    // ************************
    // Checks
    // ************************
    // Setup cycle, wait mode and an accepted status write.
    logic setup;
    logic waiting;
    logic st_wr;
    assign setup   = psel && !penable;
    assign waiting = cpu_state.wait_mode;
    assign st_wr   = psel && penable && pready && pwrite && paddr == 12'h000 && !waiting;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    answer_one_a: assert property (setup |=> pready && penable)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (setup && paddr > 12'h010 |=> pslverr)
        else $error("unmapped access accepted");
    wait_refuse_a: assert property (setup && waiting ##1 waiting |-> pslverr && prdata == 32'h0)
        else $error("access served in wait mode");
    pin_input_a: assert property (st_wr && pwdata[2:0] == 3'h7 |-> ##[1:2] ext_pin_force_input)
        else $error("pin not forced to input");
    pin_gpio_a: assert property (st_wr && pwdata[2:0] != 3'h7 |-> ##[1:2] !ext_pin_force_input)
        else $error("pin forced without pin clock");
    irq_gate_a: assert property (st_wr && !pwdata[6] |-> ##2 !overflow_irq)
        else $error("request while disabled");
    wake_cause_a: assert property (wake_request |-> $past(waiting))
        else $error("wake outside wait mode");
    wake_irq_a: assert property (waiting ##1 overflow_irq |-> wake_request)
        else $error("no wake on request");
    // Main scenarios reached.
    cover property (overflow_irq);
    cover property (wake_request);
    cover property (ext_pin_force_input);
endmodule : timer_asserts

/* verification/host_cpu_model.sv */
// Processor model that reaches the timer registers over APB.
`timescale 1ns/10ps
module host_cpu_model (
    // Bus clock.
    input  wire logic        pclk,
    // APB master.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ************************
    // Bus cycles
    // ************************
    // Idle bus from time zero.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end
    // One transfer; held until ready is seen, so a slow slave is served too.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : host_cpu_model

/* verification/testbench.sv */
// Self-checking testbench of the general timer unit.
`timescale 1ns/10ps
module testbench import timer_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        pin, dir_bit, force_in, irq, wake, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  q;
    cpu_state_t  cpu;
    int          fail_count, check_count;
    general_timer_unit u_general_timer_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_state(cpu), .ext_count_clock_pin(pin), .port_d_direction_bit(dir_bit),
        .ext_pin_force_input(force_in), .overflow_irq(irq), .wake_request(wake));
    host_cpu_model u_host_cpu_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ************************
    // Helpers
    // ************************
    // Clock at 100 MHz.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_host_cpu_model.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic get(input logic [11:0] a);
        u_host_cpu_model.xfer(1'b0, a, 8'h00, q, e);
    endtask : get
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        get(a);
        chk(q, x);
    endtask : rd
    // Run briefly from zero so a short modulo overflows, then halt.
    task automatic ovf();
        wr(12'h000, 8'h10);
        repeat (12) @(posedge pclk);
        wr(12'h000, 8'h20);
    endtask : ovf
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // ************************
    // Scenarios
    // ************************
    task automatic t_reset();
        rd(12'h000, 8'h20);
        rd(12'h00C, 8'hFF);
        rd(12'h010, 8'hFF);
        rd(12'h004, 8'h00);
        rd(12'h008, 8'h00);
        get(12'h014);
        chk({7'h0, e}, 8'h01);
        $display("reset test done");
    endtask : t_reset
    task automatic t_flag();
        wr(12'h000, 8'h30);
        wr(12'h00C, 8'h00);
        wr(12'h010, 8'h03);
        wr(12'h000, 8'h40);
        repeat (12) @(posedge pclk);
        chk({7'h0, irq}, 8'h01);
        cpu.wait_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({7'h0, wake}, 8'h01);
        get(12'h004);
        chk({7'h0, e}, 8'h01);
        cpu.wait_mode <= 1'b0;
        wr(12'h000, 8'h30);
        rd(12'h008, 8'h00);
        wr(12'h000, 8'hA0);
        rd(12'h000, 8'hA0);
        wr(12'h000, 8'h20);
        rd(12'h000, 8'h20);
        $display("flag test done");
    endtask : t_flag
    task automatic t_prescale();
        wr(12'h00C, 8'hFF);
        wr(12'h010, 8'hFF);
        for (int k = 0; k < 7; k++) begin
            wr(12'h000, {5'b00010, k[2:0]});
            repeat (64) @(posedge pclk);
            wr(12'h000, {5'b00100, k[2:0]});
            get(12'h008);
            chk({7'h0, q >= (64 >> k) && q <= (72 >> k) + 1}, 8'h01);
            rd(12'h000, {5'b00100, k[2:0]});
        end
        $display("prescale test done");
    endtask : t_prescale
    task automatic t_ext();
        dir_bit <= 1'b1;
        wr(12'h000, 8'h17);
        repeat (2) @(posedge pclk);
        chk({7'h0, force_in}, 8'h01);
        repeat (5) begin
            pin <= 1'b1;
            repeat (3) @(posedge pclk);
            pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        wr(12'h000, 8'h20);
        rd(12'h008, 8'h05);
        repeat (2) @(posedge pclk);
        chk({7'h0, force_in}, 8'h00);
        $display("pin clock test done");
    endtask : t_ext
    task automatic t_hold();
        logic [7:0] v;
        // Stop, then break, then wait: only wait lets the count run through all of it.
        for (int i = 0; i < 3; i++) begin
            wr(12'h000, 8'h10);
            cpu <= (i == 0) ? 4'b0100 : (i == 1) ? 4'b0010 : 4'b1000;
            repeat (30) @(posedge pclk);
            cpu <= 4'b0000;
            repeat (20) @(posedge pclk);
            get(12'h008);
            chk({7'h0, q >= ((i == 2) ? 8'd48 : 8'd18) && q <= ((i == 2) ? 8'd56 : 8'd26)}, 8'h01);
        end
        // High read latches; four running clocks pass before the halt lands.
        get(12'h004);
        wr(12'h000, 8'h20);
        get(12'h008);
        v = q;
        get(12'h008);
        chk(q, v + 8'h04);
        get(12'h004);
        wr(12'h000, 8'h30);
        rd(12'h004, 8'h00);
        rd(12'h008, 8'h00);
        $display("hold test done");
    endtask : t_hold
    task automatic t_break();
        wr(12'h00C, 8'h00);
        wr(12'h010, 8'h03);
        wr(12'h00C, 8'h00);
        ovf();
        rd(12'h000, 8'h20);
        wr(12'h010, 8'h03);
        ovf();
        rd(12'h000, 8'hA0);
        cpu <= 4'b0010;
        wr(12'h000, 8'h20);
        rd(12'h000, 8'hA0);
        cpu <= 4'b0000;
        wr(12'h000, 8'h20);
        rd(12'h000, 8'h20);
        ovf();
        cpu <= 4'b0011;
        rd(12'h000, 8'hA0);
        wr(12'h000, 8'h20);
        cpu <= 4'b0000;
        rd(12'h000, 8'h20);
        $display("break test done");
    endtask : t_break
    // Main sequence after a four-cycle reset.
    initial begin
        presetn = 1'b0;
        cpu = 4'b0000;
        pin = 1'b0;
        dir_bit = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flag();
        t_prescale();
        t_ext();
        t_hold();
        t_break();
        test_done();
    end
    // Watchdog well beyond the thousand or so cycles the tests need.
    initial begin
        #200us;
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end
endmodule : testbench
bind general_timer_unit timer_asserts u_timer_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_state(cpu_state), .ext_count_clock_pin(ext_count_clock_pin),
    .port_d_direction_bit(port_d_direction_bit), .ext_pin_force_input(ext_pin_force_input),
    .overflow_irq(overflow_irq), .wake_request(wake_request));
